// ### rtl/pvc_regs.sv
// Module: vendor control and quick-poll status registers of the transceiver management slice
//
// Behaviour
// - Partner next-page register low four bits show received code, read-only, reset 0.
// - Addresses 9 to 15 are reserved: read zero, writes do nothing but clear a set override write enable.
// - Extended control bit 15 is self-clearing override write enable; bits 14-11 read 0.
// - Quick-poll status is read-only; bit 15 shows rate, 1 is 100 Mbps.
// - Quick-poll status bit 14 reads 1 for full duplex, 0 for half.
// - Three-bit negotiation progress code at bits 13-11, latching maximum, reset 0.
`timescale 1ns/1ps
`default_nettype none
module pvc_regs
	import pvc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [4:0] mgmt_addr_i,
	input wire logic mgmt_wr_i,
	input wire logic mgmt_rd_i,
	input wire logic [15:0] mgmt_wdata_i,
	output logic [15:0] mgmt_rdata_o,
	input wire logic np_page_rx_i,
	input wire logic [3:0] np_code_i,
	input wire logic speed_100_i,
	input wire logic full_duplex_i,
	input wire logic [2:0] an_progress_i,
	input wire logic [4:0] phy_addr_i,
	output logic cipher_bypass_o,
	output logic tx_invalid_o,
	output logic nrzi_sel_o,
	output logic cipher_test_o,
	output logic override_we_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [PVC_NP_W-1:0] np_code;
		logic ovr_we;
		logic ciph_dis;
		logic tx_inv;
		logic nrzi;
		logic ciph_test;
		logic ad_taken;
		logic [PVC_PHYAD_W-1:0] phy_addr;
		logic [PVC_PHYAD_W-1:0] phy_sync1;
		logic [PVC_PHYAD_W-1:0] phy_sync2;
		logic [1:0] strap_cnt;
		logic rate;
		logic duplex;
		logic [PVC_ANPROG_W-1:0] an_max;
		logic [15:0] rdata;
	} pvc_state_t;

	pvc_state_t st_r;
	pvc_state_t st_nxt;

	localparam pvc_state_t PVC_ST_RST = '{
		np_code: PVC_NP_RST,
		ovr_we: PVC_OVR_RST,
		ciph_dis: PVC_CIPH_DIS_RST,
		tx_inv: PVC_TX_INV_RST,
		nrzi: PVC_NRZI_RST,
		ciph_test: PVC_CIPH_TEST_RST,
		ad_taken: 1'b0,
		phy_addr: 5'h00,
		phy_sync1: 5'h00,
		phy_sync2: 5'h00,
		strap_cnt: 2'h0,
		rate: 1'b0,
		duplex: 1'b0,
		an_max: PVC_ANPROG_RST,
		rdata: PVC_ZERO16
	};

	function automatic logic is_addr(input logic [4:0] a, input logic [4:0] ref_a);
		is_addr = (a == ref_a);
	endfunction : is_addr

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [15:0] rd;
		rd = PVC_ZERO16;
		st_nxt = st_r;
		// Strap pins pass two flip-flops before anything reads them
		st_nxt.phy_sync1 = phy_addr_i;
		st_nxt.phy_sync2 = st_r.phy_sync1;
		// Latched once the pair has filled; later strap changes wait for a reset
		if (!st_r.ad_taken)
		begin
			if (st_r.strap_cnt == PVC_STRAP_SYNC)
			begin
				st_nxt.phy_addr = st_r.phy_sync2;
				st_nxt.ad_taken = 1'b1;
			end
			else
				st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
		end
		if (np_page_rx_i)
			st_nxt.np_code = np_code_i;
		st_nxt.rate = speed_100_i;
		st_nxt.duplex = full_duplex_i;
		// Read data; unlisted and reserved addresses read zero
		if (is_addr(mgmt_addr_i, PVC_ADDR_NP_PARTNER))
			rd[PVC_NP_W-1:0] = st_r.np_code;
		else if (is_addr(mgmt_addr_i, PVC_ADDR_EXT_CTRL))
		begin
			rd[PVC_EC_OVR_WE] = st_r.ovr_we;
			rd[PVC_EC_PHYAD_LSB +: PVC_PHYAD_W] = st_r.phy_addr;
			rd[PVC_EC_CIPH_TEST] = st_r.ciph_test;
			rd[PVC_EC_NRZI] = st_r.nrzi;
			rd[PVC_EC_TX_INV] = st_r.tx_inv;
			rd[PVC_EC_CIPH_DIS] = st_r.ciph_dis;
		end
		else if (is_addr(mgmt_addr_i, PVC_ADDR_QP_STATUS))
		begin
			rd[PVC_QP_RATE] = st_r.rate;
			rd[PVC_QP_DUPLEX] = st_r.duplex;
			rd[PVC_QP_ANPROG_LSB +: PVC_ANPROG_W] = st_r.an_max;
		end
		if (mgmt_rd_i)
			st_nxt.rdata = rd;
		// Latching maximum: a read restarts from the live code so nothing is lost
		if (mgmt_rd_i && is_addr(mgmt_addr_i, PVC_ADDR_QP_STATUS))
			st_nxt.an_max = an_progress_i;
		else if (an_progress_i > st_r.an_max)
			st_nxt.an_max = an_progress_i;
		// Override enable lasts for exactly one following write
		if (mgmt_wr_i && st_r.ovr_we)
			st_nxt.ovr_we = 1'b0;
		if (mgmt_wr_i && is_addr(mgmt_addr_i, PVC_ADDR_EXT_CTRL))
		begin
			st_nxt.ovr_we = mgmt_wdata_i[PVC_EC_OVR_WE];
			st_nxt.ciph_test = mgmt_wdata_i[PVC_EC_CIPH_TEST];
			st_nxt.nrzi = mgmt_wdata_i[PVC_EC_NRZI];
			st_nxt.tx_inv = mgmt_wdata_i[PVC_EC_TX_INV];
			st_nxt.ciph_dis = mgmt_wdata_i[PVC_EC_CIPH_DIS];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			st_r <= PVC_ST_RST;
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign mgmt_rdata_o = st_r.rdata;
	assign cipher_bypass_o = st_r.ciph_dis;
	assign tx_invalid_o = st_r.tx_inv;
	assign nrzi_sel_o = st_r.nrzi;
	assign cipher_test_o = st_r.ciph_test;
	assign override_we_o = st_r.ovr_we;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// Read data and read-only fields
	a_np_code_rd: assert property (mgmt_rd_i && mgmt_addr_i == PVC_ADDR_NP_PARTNER
		|=> mgmt_rdata_o == {12'h000, $past(st_r.np_code)})
		else $error("next-page read mismatch");
	a_np_capture: assert property (np_page_rx_i |=> st_r.np_code == $past(np_code_i))
		else $error("next-page code not captured");
	a_np_hold: assert property (!np_page_rx_i |=> $stable(st_r.np_code))
		else $error("next-page code changed without a page");
	a_rsv_reads_zero: assert property (mgmt_rd_i && mgmt_addr_i >= PVC_ADDR_RSV_LO
		&& mgmt_addr_i <= PVC_ADDR_RSV_HI |=> mgmt_rdata_o == 16'h0000)
		else $error("reserved address read nonzero");

	// Control register write side
	a_rsv_wr_ignored: assert property (mgmt_wr_i && mgmt_addr_i != PVC_ADDR_EXT_CTRL
		|=> $stable({cipher_bypass_o, tx_invalid_o, nrzi_sel_o, cipher_test_o}))
		else $error("control bits changed by a foreign write");
	a_ovr_self_clear: assert property (override_we_o && mgmt_wr_i
		&& mgmt_addr_i != PVC_ADDR_EXT_CTRL |=> !override_we_o)
		else $error("override enable did not self clear");
	a_ovr_hold: assert property (override_we_o && !mgmt_wr_i |=> override_we_o)
		else $error("override enable dropped without a write");
	a_ec_rsv_zero: assert property (mgmt_rd_i && mgmt_addr_i == PVC_ADDR_EXT_CTRL
		|=> mgmt_rdata_o[14:11] == 4'h0 && mgmt_rdata_o[4] == 1'b0
		&& mgmt_rdata_o[1] == 1'b0)
		else $error("reserved control bits nonzero");
	a_ctrl_write: assert property (mgmt_wr_i && mgmt_addr_i == PVC_ADDR_EXT_CTRL |=>
		cipher_bypass_o == $past(mgmt_wdata_i[0]) && nrzi_sel_o == $past(mgmt_wdata_i[3])
		&& tx_invalid_o == $past(mgmt_wdata_i[2]) && cipher_test_o == $past(mgmt_wdata_i[5]))
		else $error("control write not applied");

	// Status path; rate and duplex are two edges old when read
	a_rate_bit: assert property (mgmt_rd_i && mgmt_addr_i == PVC_ADDR_QP_STATUS |=>
		mgmt_rdata_o[15] == $past(speed_100_i, 2))
		else $error("rate bit mismatch");
	a_duplex_bit: assert property (mgmt_rd_i && mgmt_addr_i == PVC_ADDR_QP_STATUS |=>
		mgmt_rdata_o[14] == $past(full_duplex_i, 2))
		else $error("duplex bit mismatch");
	a_anprog_latch: assert property (!(mgmt_rd_i && mgmt_addr_i == PVC_ADDR_QP_STATUS)
		|=> st_r.an_max >= $past(st_r.an_max) && st_r.an_max >= $past(an_progress_i))
		else $error("progress code dropped");

	// Strap capture
	a_strap_hold: assert property (st_r.ad_taken
		|=> st_r.ad_taken && $stable(st_r.phy_addr))
		else $error("strap address changed after capture");

	// Main scenarios
	c_ctrl_write: cover property (mgmt_wr_i && mgmt_addr_i == PVC_ADDR_EXT_CTRL);
	c_ovr_cycle: cover property (override_we_o ##1 !override_we_o);
	c_anprog_rd: cover property (mgmt_rd_i && mgmt_addr_i == PVC_ADDR_QP_STATUS
		&& st_r.an_max != 3'h0);
	c_np_page: cover property (np_page_rx_i);
	c_rsv_read: cover property (mgmt_rd_i && mgmt_addr_i == PVC_ADDR_RSV_LO);
endmodule : pvc_regs
`default_nettype wire

// ### rtl/pvc_pkg.sv
// Package: register map, field positions and reset values of the vendor register slice
package pvc_pkg;
	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [4:0] PVC_ADDR_NP_PARTNER = 5'h08;
	localparam logic [4:0] PVC_ADDR_RSV_LO = 5'h09;
	localparam logic [4:0] PVC_ADDR_RSV_HI = 5'h0F;
	localparam logic [4:0] PVC_ADDR_EXT_CTRL = 5'h10;
	localparam logic [4:0] PVC_ADDR_QP_STATUS = 5'h11;

	// ----------------------------------------------------------------
	// Extended control field positions
	// ----------------------------------------------------------------
	localparam int PVC_EC_OVR_WE = 15;
	localparam int PVC_EC_PHYAD_LSB = 6;
	localparam int PVC_EC_CIPH_TEST = 5;
	localparam int PVC_EC_NRZI = 3;
	localparam int PVC_EC_TX_INV = 2;
	localparam int PVC_EC_CIPH_DIS = 0;

	// ----------------------------------------------------------------
	// Quick-poll status field positions
	// ----------------------------------------------------------------
	localparam int PVC_QP_RATE = 15;
	localparam int PVC_QP_DUPLEX = 14;
	localparam int PVC_QP_ANPROG_LSB = 11;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int PVC_NP_W = 4;
	localparam int PVC_PHYAD_W = 5;
	localparam int PVC_ANPROG_W = 3;
	localparam logic [3:0] PVC_NP_RST = 4'h0;
	localparam logic [2:0] PVC_ANPROG_RST = 3'h0;
	localparam logic PVC_OVR_RST = 1'b0;
	localparam logic PVC_CIPH_DIS_RST = 1'b0;
	localparam logic PVC_TX_INV_RST = 1'b0;
	localparam logic PVC_NRZI_RST = 1'b1;
	localparam logic PVC_CIPH_TEST_RST = 1'b0;
	localparam logic [15:0] PVC_ZERO16 = 16'h0000;
	localparam logic [1:0] PVC_STRAP_SYNC = 2'h2;
endpackage : pvc_pkg

// ### tb/pvc_sta_model.sv
// Management station model driving the register port
`timescale 1ns/1ps
`default_nettype none
module pvc_sta_model (
	input wire logic ref_clk_i,
	output logic [4:0] mgmt_addr_o,
	output logic mgmt_wr_o,
	output logic mgmt_rd_o,
	output logic [15:0] mgmt_wdata_o
);
	initial
	begin
		{mgmt_wr_o, mgmt_rd_o} = 2'h0;
		mgmt_addr_o = 5'h1F;
		mgmt_wdata_o = 16'hA5A5;
	end
	// Stale address and data are inverted, never left looking valid
	task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(negedge ref_clk_i);
		mgmt_wr_o = w;
		mgmt_rd_o = ~w;
		mgmt_addr_o = a;
		mgmt_wdata_o = d;
		@(negedge ref_clk_i);
		{mgmt_wr_o, mgmt_rd_o} = 2'h0;
		mgmt_addr_o = ~a;
		mgmt_wdata_o = ~d;
	endtask : xfer
endmodule : pvc_sta_model
`default_nettype wire

// ### tb/pvc_regs_test.sv
// Testbench for the vendor control and quick-poll register slice
`timescale 1ns/1ps
`default_nettype none
module pvc_regs_test import pvc_pkg::*;;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [4:0] addr;
	logic [15:0] wdata, rdata, exp_q[$];
	logic wr, rd, np_rx, spd, dup;
	logic rd_d = 1'b0;
	logic [3:0] np;
	logic [2:0] an;
	logic [4:0] ctl;
	logic [4:0] strap = 5'h15;
	int err_count = 0;
	int n_tests = 0;
	int seed = 23;
	int a;
	always #5 ref_clk_i = ~ref_clk_i;
	pvc_sta_model u_sta (.ref_clk_i(ref_clk_i), .mgmt_addr_o(addr), .mgmt_wr_o(wr),
		.mgmt_rd_o(rd), .mgmt_wdata_o(wdata));
	pvc_regs dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .mgmt_addr_i(addr), .mgmt_wr_i(wr),
		.mgmt_rd_i(rd), .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata), .np_page_rx_i(np_rx),
		.np_code_i(np), .speed_100_i(spd), .full_duplex_i(dup), .an_progress_i(an),
		.phy_addr_i(strap), .cipher_bypass_o(ctl[0]), .tx_invalid_o(ctl[1]),
		.nrzi_sel_o(ctl[2]), .cipher_test_o(ctl[3]), .override_we_o(ctl[4]));
	// ----------------------------------------------------------------
	// Compare and report
	// ----------------------------------------------------------------
	task automatic chk_rd(input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] rdata expected %h seen %h", e, g);
		end
	endtask : chk_rd
	task automatic chk_ctl(input logic [4:0] e, input logic [4:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] ctl expected %b seen %b", e, g);
		end
	endtask : chk_ctl
	task automatic results;
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	task automatic rd_exp(input logic [4:0] ad, input logic [15:0] e);
		exp_q.push_back(e);
		u_sta.xfer(1'b0, ad, 16'h0000);
	endtask : rd_exp
	always @(posedge ref_clk_i)
		rd_d <= rd;
	// A read with no note queued is a mismatch in itself
	always @(negedge ref_clk_i)
		if (rd_d === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				err_count++;
				$display("[ERR] rdata expected nothing seen %h", rdata);
			end
			else
				chk_rd(exp_q.pop_front(), rdata);
		end
	initial
	begin
		repeat (5000) @(posedge ref_clk_i);
		err_count++;
		results();
	end
	initial
	begin
		{np_rx, np, an} = 8'h00;
		spd = 1'($random(seed));
		dup = 1'($random(seed));
		repeat (10) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		chk_ctl(5'b00100, ctl);
		rd_exp(PVC_ADDR_EXT_CTRL, 16'h0548);
		u_sta.xfer(1'b1, PVC_ADDR_EXT_CTRL, 16'hFFFF);
		chk_ctl(5'b11111, ctl);
		rd_exp(PVC_ADDR_EXT_CTRL, 16'h856D);
		for (a = 8; a <= 17; a++)
			if (a != 16)
				u_sta.xfer(1'b1, 5'(a), 16'($random(seed)));
		chk_ctl(5'b01111, ctl);
		for (a = 9; a <= 15; a++)
			rd_exp(5'(a), 16'h0000);
		rd_exp(PVC_ADDR_NP_PARTNER, 16'h0000);
		@(negedge ref_clk_i);
		np = 4'($random(seed));
		np_rx = 1'b1;
		@(negedge ref_clk_i);
		np_rx = 1'b0;
		rd_exp(PVC_ADDR_NP_PARTNER, {12'h000, np});
		u_sta.xfer(1'b1, PVC_ADDR_EXT_CTRL, 16'h0000);
		chk_ctl(5'b00000, ctl);
		an = 3'h5;
		repeat (2) @(negedge ref_clk_i);
		an = 3'h2;
		repeat (2) @(negedge ref_clk_i);
		rd_exp(PVC_ADDR_QP_STATUS, {spd, dup, 3'h5, 11'h000});
		rd_exp(PVC_ADDR_QP_STATUS, {spd, dup, 3'h2, 11'h000});
		{spd, dup} = ~{spd, dup};
		repeat (2) @(negedge ref_clk_i);
		rd_exp(PVC_ADDR_QP_STATUS, {spd, dup, 3'h2, 11'h000});
		@(negedge ref_clk_i);
		rstn_i = 1'b0;
		strap = 5'h0A;
		repeat (3) @(negedge ref_clk_i);
		chk_ctl(5'b00100, ctl);
		chk_rd(16'h0000, rdata);
		rstn_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		rd_exp(PVC_ADDR_EXT_CTRL, 16'h0288);
		rd_exp(PVC_ADDR_NP_PARTNER, 16'h0000);
		repeat (3) @(negedge ref_clk_i);
		results();
	end
endmodule : pvc_regs_test
`default_nettype wire
